// [rtl/lcrm_pkg.sv]
// Shared constants and carriers for the legacy compatible register mapper
package lcrm_pkg;

    // Register port widths
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;

    // Legacy register offsets
    localparam logic [6:0] ADDR_POWER  = 7'h06;  // power_enables
    localparam logic [6:0] ADDR_FORMAT = 7'h07;  // serial_format_ctrl
    localparam logic [6:0] ADDR_RATE   = 7'h08;  // sample_rate_ctrl
    localparam logic [6:0] ADDR_BIAS   = 7'h09;  // bias_current_ctrl
    localparam logic [6:0] ADDR_REFIMP = 7'h0A;  // ref_impedance_ctrl
    localparam logic [6:0] ADDR_GATE   = 7'h0B;  // noise_gate_ctrl
    localparam logic [6:0] ADDR_LEVEL  = 7'h0C;  // level_ctrl_gain_ctrl
    localparam int         LEGACY_N    = 7;      // Legacy registers in the bank

    // Native register offsets touched by the mapping
    localparam logic [6:0] ADDR_NAT_PWR  = 7'h21;  // Write-only extra power enables
    localparam logic [6:0] ADDR_NAT_REF  = 7'h22;  // Negative input to reference
    localparam logic [6:0] ADDR_NAT_CLK  = 7'h26;  // Clock dividers
    localparam logic [6:0] ADDR_NAT_SRT  = 7'h27;  // Native rate field
    localparam logic [6:0] ADDR_PATH_L   = 7'h4B;  // Left channel path
    localparam logic [6:0] ADDR_PATH_R   = 7'h4C;  // Right channel path

    // power_enables fields
    localparam int PWR_MID_REF = 8;
    localparam int PWR_BUF_OFF = 7;
    localparam int PWR_PORT    = 6;
    localparam int PWR_PGA2_L  = 5;
    localparam int PWR_PGA2_R  = 4;
    localparam int PWR_CONV_L  = 3;
    localparam int PWR_CONV_R  = 2;

    // serial_format_ctrl fields
    localparam int FMT_OUT_DIS = 7;
    localparam int FMT_ROLE    = 6;
    localparam int FMT_FS_INV  = 4;
    localparam int FMT_WORD_LENGTH    = 2;
    localparam int FMT_FRAME   = 0;

    // sample_rate_ctrl, noise_gate_ctrl and level_ctrl_gain_ctrl fields
    localparam int RATE_HALVE  = 6;
    localparam int RATE_CODE   = 1;
    localparam int GATE_EN     = 0;
    localparam int GATE_TH     = 2;
    localparam int FLOOR_GAIN  = 5;
    localparam int LVL_CH_EN   = 7;
    localparam int CEIL_GAIN   = 4;
    localparam int LVL_TARGET  = 0;

    // Native fields
    localparam int NAT_BIAS     = 3;
    localparam int NAT_TIEOFF   = 2;
    localparam int PATH_POS     = 0;
    localparam int PATH_NEG1    = 1;
    localparam int PATH_SEC1    = 2;
    localparam int PATH_NEG2    = 5;
    localparam int PATH_SEC2    = 6;
    localparam int NAT_MAIN_DIV = 5;
    localparam int NAT_BIT_DIV  = 2;
    localparam int NAT_RATE     = 1;

    // Reset values
    localparam logic [8:0] LEGACY_RST = 9'h000;
    localparam logic [6:0] PATH_RST   = 7'h00;
    localparam logic [1:0] NATPWR_RST = 2'h0;

    // Frame formats
    localparam logic [1:0] FRAME_RJ  = 2'h0;
    localparam logic [1:0] FRAME_DSP = 2'h3;

    // Rate codes with a native mapping
    localparam logic [4:0] RATE_8K  = 5'h04;
    localparam logic [4:0] RATE_12K = 5'h08;
    localparam logic [4:0] RATE_16K = 5'h0A;
    localparam logic [4:0] RATE_24K = 5'h1C;
    localparam logic [4:0] RATE_32K = 5'h0C;
    localparam logic [4:0] RATE_48K = 5'h00;

    // Decoded legacy power controls
    typedef struct packed {
        logic mid_ref_enable;
        logic ref_buffer_on;
        logic serial_port_power;
        logic left_pga2_power;
        logic right_pga2_power;
        logic left_conv_enable;
        logic right_conv_enable;
    } lcrm_power_t;

    // Decoded serial port format
    typedef struct packed {
        logic       sample_out_enable;
        logic       port_role_select;
        logic       frame_sync_invert;
        logic       dsp_variant_b;
        logic [1:0] frame_format;
        logic [5:0] word_bits;
        logic       main_clock_halve;
    } lcrm_format_t;

    // Live native mapped state
    typedef struct packed {
        logic            bias_block_enable;
        logic            tieoff_buffer_enable;
        logic [1:0]      neg_input_to_ref;
        logic [1:0][6:0] path;
        logic [2:0]      main_clock_divider;
        logic [4:0]      main_div_x2;
        logic [2:0]      bit_clock_divider;
        logic [2:0]      native_rate_field;
    } lcrm_native_t;

    // Decoded gate and level control settings
    typedef struct packed {
        logic              gate_enable;
        logic signed [7:0] gate_threshold_db;
        logic signed [7:0] floor_gain_db;
        logic signed [8:0] ceiling_gain_qdb;
        logic [1:0]        level_ctrl_channel_enable;
        logic signed [6:0] target_hdb;
    } lcrm_level_t;

    // Result of a rate code lookup
    typedef struct packed {
        logic       hit;
        logic [2:0] main_div;
        logic [2:0] bit_div;
        logic [2:0] rate;
    } lcrm_rate_map_t;

endpackage

// [rtl/lcrm_mapper.sv]
`timescale 1ns/100ps

module lcrm_mapper #(
    parameter int ADDR_W = lcrm_pkg::ADDR_W,  // Register address width
    parameter int DATA_W = lcrm_pkg::DATA_W   // Register data width
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_srst,
    // Register access port
    input  wire logic                   i_wr_en,
    input  wire logic                   i_rd_en,
    input  wire logic [ADDR_W-1:0]      i_addr,
    input  wire logic [DATA_W-1:0]      i_wdata,
    output logic      [DATA_W-1:0]      o_rdata,
    output logic                        o_rd_valid,
    // Device status inputs
    input  wire logic                   i_mclk_present,
    input  wire logic                   i_out_enable_source_sel,
    input  wire logic                   i_target_table_select,
    // Decoded controls
    output lcrm_pkg::lcrm_power_t       o_power,
    output lcrm_pkg::lcrm_format_t      o_format,
    output lcrm_pkg::lcrm_native_t      o_native,
    output lcrm_pkg::lcrm_level_t       o_level
);

    // Rate code lookup into divider and native rate values
    function automatic lcrm_pkg::lcrm_rate_map_t rate_lookup(input logic [4:0] code);
        lcrm_pkg::lcrm_rate_map_t m;
        m = '{hit: 1'b1, main_div: 3'h0, bit_div: 3'h2, rate: 3'h0};
        case (code)
            lcrm_pkg::RATE_8K: begin
                m.main_div = 3'h5;
                m.rate     = 3'h5;
            end
            lcrm_pkg::RATE_12K: begin
                m.main_div = 3'h4;
                m.rate     = 3'h4;
            end
            lcrm_pkg::RATE_16K: begin
                m.main_div = 3'h3;
                m.bit_div  = 3'h6;
                m.rate     = 3'h3;
            end
            lcrm_pkg::RATE_24K: begin
                m.main_div = 3'h2;
                m.rate     = 3'h2;
            end
            lcrm_pkg::RATE_32K: begin
                m.main_div = 3'h1;
                m.rate     = 3'h1;
            end
            lcrm_pkg::RATE_48K: begin
                m.main_div = 3'h0;
                m.rate     = 3'h0;
            end
            // Codes with no native mapping leave the dividers alone
            default: begin
                m.hit = 1'b0;
            end
        endcase
        return m;
    endfunction

    // Main divider code to twice the division ratio
    function automatic logic [4:0] main_div_x2(input logic [2:0] code);
        logic [4:0] r;
        r = 5'h02;
        case (code)
            3'h0: r = 5'h02;
            3'h1: r = 5'h03;
            3'h2: r = 5'h04;
            3'h3: r = 5'h06;
            3'h4: r = 5'h08;
            3'h5: r = 5'h0C;
            3'h6: r = 5'h10;
            default: r = 5'h18;
        endcase
        return r;
    endfunction

    // Channel path value after a converter enable rises or falls
    function automatic logic [6:0] path_map(input logic [6:0] cur, input logic rise);
        logic [6:0] set_m;
        logic [6:0] clr_m;
        set_m = 7'h00;
        clr_m = 7'h00;
        set_m[lcrm_pkg::PATH_POS]  = 1'b1;
        set_m[lcrm_pkg::PATH_SEC2] = 1'b1;
        clr_m[lcrm_pkg::PATH_NEG1] = 1'b1;
        clr_m[lcrm_pkg::PATH_SEC1] = 1'b1;
        clr_m[lcrm_pkg::PATH_NEG2] = 1'b1;
        return rise ? ((cur | set_m) & ~clr_m) : (cur & ~(set_m | clr_m));
    endfunction

    // Legacy register bank, indexed from the power register
    logic [DATA_W-1:0]  legacy_q [lcrm_pkg::LEGACY_N];
    // Native mapped state
    logic [1:0]         natpwr_q;     // Stored write-only native power bits
    logic [1:0]         bias_eff_q;   // Live bias and tie-off enables
    logic [1:0]         ref_q;        // Negative input to reference, [1] left
    logic [1:0][6:0]    path_q;       // Channel path registers, [1] left
    logic [1:0][6:0]    path_d;
    logic [5:0]         clk_q;        // Main and bit clock dividers
    logic [2:0]         srt_q;        // Native rate field
    // Read return
    logic [DATA_W-1:0]  rdata_q;
    logic               rd_valid_q;

    // Address decode
    wire logic [2:0] legacy_idx = 3'(i_addr - lcrm_pkg::ADDR_POWER);
    wire logic in_legacy  = (i_addr >= lcrm_pkg::ADDR_POWER) && (i_addr <= lcrm_pkg::ADDR_LEVEL);
    wire logic wr_legacy  = i_wr_en && in_legacy;
    wire logic wr_power   = i_wr_en && (i_addr == lcrm_pkg::ADDR_POWER);
    wire logic wr_rate    = i_wr_en && (i_addr == lcrm_pkg::ADDR_RATE);
    wire logic wr_natpwr  = i_wr_en && (i_addr == lcrm_pkg::ADDR_NAT_PWR);
    wire logic wr_natref  = i_wr_en && (i_addr == lcrm_pkg::ADDR_NAT_REF);
    wire logic wr_natclk  = i_wr_en && (i_addr == lcrm_pkg::ADDR_NAT_CLK);
    wire logic wr_natsrt  = i_wr_en && (i_addr == lcrm_pkg::ADDR_NAT_SRT);

    // Handy views of the stored legacy registers
    wire logic [8:0] pwr_reg   = legacy_q[0];
    wire logic [8:0] fmt_reg   = legacy_q[1];
    wire logic [8:0] rate_reg  = legacy_q[2];
    wire logic [8:0] gate_reg  = legacy_q[5];
    wire logic [8:0] level_reg = legacy_q[6];

    // Without the master clock the converter enables keep their old value
    wire logic [1:0] conv_old = pwr_reg[lcrm_pkg::PWR_CONV_L:lcrm_pkg::PWR_CONV_R];
    wire logic [1:0] conv_wr  = i_mclk_present ? i_wdata[lcrm_pkg::PWR_CONV_L:lcrm_pkg::PWR_CONV_R]
                                               : conv_old;
    wire logic [8:0] pwr_wval = {i_wdata[8:4], conv_wr, i_wdata[1:0]};
    wire logic [8:0] legacy_wval = (legacy_idx == 3'h0) ? pwr_wval : i_wdata;

    // Converter enable edges caused by this write, [1] left
    wire logic [1:0] conv_new  = wr_power ? conv_wr : conv_old;
    wire logic [1:0] conv_rise = conv_new & ~conv_old;
    wire logic [1:0] conv_fall = conv_old & ~conv_new;
    wire logic       all_off   = (|conv_old) && !(|conv_new);

    // Rate code mapping for a write to the rate register
    wire lcrm_pkg::lcrm_rate_map_t rmap = rate_lookup(i_wdata[5:1]);
    wire logic rate_hit = wr_rate && rmap.hit;

    // Next value of the live bias and tie-off enables
    wire logic [1:0] bias_eff_d = wr_natpwr  ? i_wdata[lcrm_pkg::NAT_BIAS:lcrm_pkg::NAT_TIEOFF]
                                : (|conv_rise) ? 2'h3
                                : all_off    ? natpwr_q
                                : bias_eff_q;

    // Per channel path bits, channel 1 is left
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        wire logic [6:0] path_addr = (ch == 1) ? lcrm_pkg::ADDR_PATH_L : lcrm_pkg::ADDR_PATH_R;
        wire logic       wr_path   = i_wr_en && (i_addr == path_addr);
        // Direct write, then mapping on enable, then mapping on disable
        assign path_d[ch] = wr_path       ? i_wdata[6:0]
                          : conv_rise[ch] ? path_map(path_q[ch], 1'b1)
                          : conv_fall[ch] ? path_map(path_q[ch], 1'b0)
                          : path_q[ch];
    end

    // Next value of the reference connection bits
    wire logic [1:0] ref_d = wr_natref ? i_wdata[1:0]
                           : ((ref_q | conv_rise) & ~conv_fall);

    // Next value of the clock dividers and native rate
    wire logic [5:0] clk_d = wr_natclk ? i_wdata[7:2]
                           : rate_hit  ? {rmap.main_div, rmap.bit_div}
                           : clk_q;
    wire logic [2:0] srt_d = wr_natsrt ? i_wdata[3:1]
                           : rate_hit  ? rmap.rate
                           : srt_q;

    // Read mux; the native power register reads zero, legacy is never refreshed from native
    wire logic [8:0] rdata_d = in_legacy ? legacy_q[legacy_idx]
        : (i_addr == lcrm_pkg::ADDR_NAT_PWR) ? 9'h000
        : (i_addr == lcrm_pkg::ADDR_NAT_REF) ? {7'h00, ref_q}
        : (i_addr == lcrm_pkg::ADDR_NAT_CLK) ? {1'b0, clk_q, 2'h0}
        : (i_addr == lcrm_pkg::ADDR_NAT_SRT) ? {5'h00, srt_q, 1'b0}
        : (i_addr == lcrm_pkg::ADDR_PATH_L)  ? {2'h0, path_q[1]}
        : (i_addr == lcrm_pkg::ADDR_PATH_R)  ? {2'h0, path_q[0]}
        : 9'h000;

    // Legacy register storage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int i = 0; i < lcrm_pkg::LEGACY_N; i++) begin
                legacy_q[i] <= lcrm_pkg::LEGACY_RST;
            end
        end else if (wr_legacy) begin
            legacy_q[legacy_idx] <= legacy_wval;
        end
    end

    // Native state, all mapping lands on the same edge as the write
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            natpwr_q   <= lcrm_pkg::NATPWR_RST;
            bias_eff_q <= lcrm_pkg::NATPWR_RST;
            ref_q      <= 2'h0;
            path_q     <= {lcrm_pkg::PATH_RST, lcrm_pkg::PATH_RST};
            clk_q      <= 6'h00;
            srt_q      <= 3'h0;
        end else begin
            // Stored copy used only for restoration
            if (wr_natpwr) begin
                natpwr_q <= i_wdata[lcrm_pkg::NAT_BIAS:lcrm_pkg::NAT_TIEOFF];
            end
            bias_eff_q <= bias_eff_d;
            ref_q      <= ref_d;
            path_q     <= path_d;
            clk_q      <= clk_d;
            srt_q      <= srt_d;
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_q    <= 9'h000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en;
            if (i_rd_en) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign o_rdata    = rdata_q;
    assign o_rd_valid = rd_valid_q;

    // Power decode
    lcrm_pkg::lcrm_power_t power_d;
    assign power_d.mid_ref_enable    = pwr_reg[lcrm_pkg::PWR_MID_REF];
    assign power_d.ref_buffer_on     = ~pwr_reg[lcrm_pkg::PWR_BUF_OFF];
    assign power_d.serial_port_power = pwr_reg[lcrm_pkg::PWR_PORT];
    assign power_d.left_pga2_power   = pwr_reg[lcrm_pkg::PWR_PGA2_L];
    assign power_d.right_pga2_power  = pwr_reg[lcrm_pkg::PWR_PGA2_R];
    assign power_d.left_conv_enable  = pwr_reg[lcrm_pkg::PWR_CONV_L];
    assign power_d.right_conv_enable = pwr_reg[lcrm_pkg::PWR_CONV_R];

    // Format decode
    wire logic [1:0] frame  = fmt_reg[lcrm_pkg::FMT_FRAME+1:lcrm_pkg::FMT_FRAME];
    wire logic [1:0] word_length   = fmt_reg[lcrm_pkg::FMT_WORD_LENGTH+1:lcrm_pkg::FMT_WORD_LENGTH];
    wire logic       fs_inv = fmt_reg[lcrm_pkg::FMT_FS_INV];
    wire logic       is_dsp = (frame == lcrm_pkg::FRAME_DSP);
    lcrm_pkg::lcrm_format_t format_d;
    // Disable bit only steers the output while the source select is clear
    assign format_d.sample_out_enable = i_out_enable_source_sel | ~fmt_reg[lcrm_pkg::FMT_OUT_DIS];
    assign format_d.port_role_select  = fmt_reg[lcrm_pkg::FMT_ROLE];
    assign format_d.frame_sync_invert = fs_inv & ~is_dsp;
    assign format_d.dsp_variant_b     = fs_inv & is_dsp;
    assign format_d.frame_format      = frame;
    assign format_d.word_bits = (frame == lcrm_pkg::FRAME_RJ) ? 6'h18
                              : (word_length == 2'h0) ? 6'h10
                              : (word_length == 2'h1) ? 6'h14
                              : (word_length == 2'h2) ? 6'h18 : 6'h20;
    assign format_d.main_clock_halve  = rate_reg[lcrm_pkg::RATE_HALVE];

    // Native view
    lcrm_pkg::lcrm_native_t native_d;
    assign native_d.bias_block_enable    = bias_eff_q[1];
    assign native_d.tieoff_buffer_enable = bias_eff_q[0];
    assign native_d.neg_input_to_ref     = ref_q;
    assign native_d.path                 = path_q;
    assign native_d.main_clock_divider   = clk_q[5:3];
    assign native_d.main_div_x2          = main_div_x2(clk_q[5:3]);
    assign native_d.bit_clock_divider    = clk_q[2:0];
    assign native_d.native_rate_field    = srt_q;

    // Gate and level decode in dB, quarter dB and half dB units
    wire logic [2:0] th_code   = gate_reg[lcrm_pkg::GATE_TH+2:lcrm_pkg::GATE_TH];
    wire logic [2:0] floor_c   = gate_reg[lcrm_pkg::FLOOR_GAIN+2:lcrm_pkg::FLOOR_GAIN];
    wire logic [2:0] ceil_c    = level_reg[lcrm_pkg::CEIL_GAIN+2:lcrm_pkg::CEIL_GAIN];
    wire logic [3:0] target_c  = level_reg[lcrm_pkg::LVL_TARGET+3:lcrm_pkg::LVL_TARGET];
    lcrm_pkg::lcrm_level_t level_d;
    assign level_d.gate_enable       = gate_reg[lcrm_pkg::GATE_EN];
    assign level_d.gate_threshold_db = (th_code == 3'h7) ? 8'shE2
                                     : 8'(-78 + 6 * int'(th_code));
    assign level_d.floor_gain_db     = 8'(-12 + 6 * int'(floor_c));
    assign level_d.level_ctrl_channel_enable = level_reg[lcrm_pkg::LVL_CH_EN+1:lcrm_pkg::LVL_CH_EN];
    assign level_d.ceiling_gain_qdb  = 9'(-27 + 24 * int'(ceil_c));
    // Second table saturates at its top two codes
    assign level_d.target_hdb = !i_target_table_select ? 7'(-57 + 3 * int'(target_c))
                              : (target_c >= 4'hE)     ? 7'sh7D
                              : 7'(-45 + 3 * int'(target_c));

    // Decoded outputs come from flip-flops
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_power  <= '0;
            o_format <= '0;
            o_native <= '0;
            o_level  <= '0;
        end else begin
            o_power  <= power_d;
            o_format <= format_d;
            o_native <= native_d;
            o_level  <= level_d;
        end
    end

endmodule

// [bench/lcrm_mapper_assertions.sv]
`timescale 1ns/100ps
// Checks port timing and mapping effects of the register mapper
module lcrm_mapper_assertions #(
    parameter int ADDR_W = 7,  // Register address width
    parameter int DATA_W = 9   // Register data width
) (
    // Clock, reset and register port
    input wire logic                   i_clk,
    input wire logic                   i_srst,
    input wire logic                   i_wr_en,
    input wire logic                   i_rd_en,
    input wire logic [ADDR_W-1:0]      i_addr,
    input wire logic [DATA_W-1:0]      i_wdata,
    input wire logic [DATA_W-1:0]      o_rdata,
    input wire logic                   o_rd_valid,
    // Status inputs and decoded outputs
    input wire logic                   i_mclk_present,
    input wire logic                   i_out_enable_source_sel,
    input wire logic                   i_target_table_select,
    input wire lcrm_pkg::lcrm_power_t  o_power,
    input wire lcrm_pkg::lcrm_format_t o_format,
    input wire lcrm_pkg::lcrm_native_t o_native,
    input wire lcrm_pkg::lcrm_level_t  o_level
);
    // Decoded register writes
    wire wr_pwr  = i_wr_en && i_addr == lcrm_pkg::ADDR_POWER;
    wire wr_fmt  = i_wr_en && i_addr == lcrm_pkg::ADDR_FORMAT;
    wire wr_rate = i_wr_en && i_addr == lcrm_pkg::ADDR_RATE;
    // Left converter turned on or off while the master clock runs
    wire left_up = wr_pwr && i_mclk_present && i_wdata[3] && !o_power.left_conv_enable;
    wire left_dn = wr_pwr && i_mclk_present && !i_wdata[3] && o_power.left_conv_enable;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Quiet cycle on both sides so no native write can interfere
    sequence s_left_on; !i_wr_en ##1 left_up ##1 !i_wr_en; endsequence
    sequence s_left_off; !i_wr_en ##1 left_dn ##1 !i_wr_en; endsequence
    property p_rd_valid; i_rd_en |=> o_rd_valid; endproperty
    property p_mid_ref; wr_pwr |=> ##1 o_power.mid_ref_enable == $past(i_wdata[8], 2)
        && o_power.ref_buffer_on != $past(i_wdata[7], 2); endproperty
    property p_port_pwr; wr_pwr |=> ##1 o_power.serial_port_power == $past(i_wdata[6], 2)
        && o_power.left_pga2_power == $past(i_wdata[5], 2); endproperty
    property p_no_clk; wr_pwr && !i_mclk_present |=> ##1 $stable(o_power.left_conv_enable)
        && $stable(o_power.right_conv_enable); endproperty
    property p_bias_on; s_left_on |=> o_native.bias_block_enable && o_native.tieoff_buffer_enable; endproperty
    property p_path_on; s_left_on |=> (o_native.path[1] & 7'h41) == 7'h41 && o_native.neg_input_to_ref[1]; endproperty
    property p_path_clr; s_left_on |=> (o_native.path[1] & 7'h26) == 7'h00; endproperty
    property p_path_off; s_left_off |=> (o_native.path[1] & 7'h67) == 7'h00 && !o_native.neg_input_to_ref[1];
    endproperty
    property p_out_dis; (wr_fmt && !i_out_enable_source_sel) ##1 !i_out_enable_source_sel [*2]
        |-> o_format.sample_out_enable != $past(i_wdata[7], 2); endproperty
    property p_rj_len; wr_fmt && i_wdata[1:0] == lcrm_pkg::FRAME_RJ |=> ##1 o_format.word_bits == 6'h18; endproperty
    property p_rate; wr_rate && i_wdata[5:1] == lcrm_pkg::RATE_16K ##1 !i_wr_en |=> o_native.main_clock_divider
        == 3'h3 && o_native.bit_clock_divider == 3'h6 && o_native.native_rate_field == 3'h3; endproperty
    property p_wo_read; i_rd_en && i_addr == lcrm_pkg::ADDR_NAT_PWR |=> o_rdata == 9'h000; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
    a_mid_ref: assert property (p_mid_ref) else $error("reference enables wrong");
    a_port_pwr: assert property (p_port_pwr) else $error("port or amplifier power wrong");
    a_no_clk: assert property (p_no_clk) else $error("converter enable changed without clock");
    a_bias_on: assert property (p_bias_on) else $error("bias or tie-off not forced");
    a_path_on: assert property (p_path_on) else $error("path bits not set");
    a_path_clr: assert property (p_path_clr) else $error("path bits not cleared");
    a_path_off: assert property (p_path_off) else $error("path bits kept after disable");
    a_out_dis: assert property (p_out_dis) else $error("sample output enable wrong");
    a_rj_len: assert property (p_rj_len) else $error("right justified length not 24");
    a_rate: assert property (p_rate) else $error("rate mapping wrong");
    a_wo_read: assert property (p_wo_read) else $error("write-only register readable");
    // Main scenarios reached
    c_left_on: cover property (s_left_on);
    c_left_off: cover property (s_left_off);
    c_rate: cover property (wr_rate && i_wdata[5:1] == lcrm_pkg::RATE_16K);
endmodule

bind lcrm_mapper lcrm_mapper_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_lcrm_mapper_assertions (
    .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .i_mclk_present(i_mclk_present),
    .i_out_enable_source_sel(i_out_enable_source_sel), .i_target_table_select(i_target_table_select),
    .o_power(o_power), .o_format(o_format), .o_native(o_native), .o_level(o_level));

// [bench/lcrm_mapper_bench.sv]
`timescale 1ns/100ps
// Self-checking bench for the register mapper
module lcrm_mapper_bench;
    // Table row: clock present, write address and data, read address and expected data
    typedef struct packed {logic mclk; logic [6:0] wa; logic [8:0] wd; logic [6:0] ra; logic [8:0] exp;} lcrm_row_t;
    logic                   i_clk = 1'b0;                   // System clock
    logic                   i_srst = 1'b1;                  // Held high at start
    logic                   i_wr_en = 1'b0;                 // Write strobe
    logic                   i_rd_en = 1'b0;                 // Read strobe
    logic [6:0]             i_addr = 7'h00;                 // Register address
    logic [8:0]             i_wdata = 9'h000;               // Write data
    logic                   i_mclk_present = 1'b1;          // Master clock running
    logic                   i_out_enable_source_sel = 1'b0; // Output enable source
    logic                   i_target_table_select = 1'b0;   // Target table choice
    logic [8:0]             o_rdata;
    logic                   o_rd_valid;
    lcrm_pkg::lcrm_power_t  o_power;
    lcrm_pkg::lcrm_format_t o_format;
    lcrm_pkg::lcrm_native_t o_native;
    lcrm_pkg::lcrm_level_t  o_level;
    int                     errors = 0;
    int                     total_checks = 0;
    // Ordinary cases, each row a write followed at once by a read
    localparam lcrm_row_t ROWS [19] = '{
        '{1'h1, 7'h08, 9'h008, 7'h26, 9'h0A8}, '{1'h1, 7'h08, 9'h010, 7'h26, 9'h088},
        '{1'h1, 7'h08, 9'h014, 7'h26, 9'h078}, '{1'h1, 7'h08, 9'h038, 7'h26, 9'h048},
        '{1'h1, 7'h08, 9'h018, 7'h26, 9'h028}, '{1'h1, 7'h08, 9'h000, 7'h26, 9'h008},
        '{1'h1, 7'h08, 9'h070, 7'h26, 9'h008}, '{1'h1, 7'h07, 9'h0D0, 7'h07, 9'h0D0},
        '{1'h1, 7'h0B, 9'h0FD, 7'h0B, 9'h0FD}, '{1'h1, 7'h0C, 9'h1FF, 7'h0C, 9'h1FF},
        '{1'h1, 7'h0A, 9'h00F, 7'h0A, 9'h00F}, '{1'h1, 7'h21, 9'h000, 7'h21, 9'h000},
        '{1'h1, 7'h06, 9'h1C8, 7'h4B, 9'h041}, '{1'h1, 7'h06, 9'h1C8, 7'h22, 9'h002},
        '{1'h1, 7'h4B, 9'h07F, 7'h4B, 9'h07F}, '{1'h1, 7'h4C, 9'h010, 7'h06, 9'h1C8},
        '{1'h1, 7'h06, 9'h040, 7'h4B, 9'h018}, '{1'h0, 7'h06, 9'h04C, 7'h06, 9'h040},
        '{1'h1, 7'h10, 9'h1FF, 7'h10, 9'h000}};
    lcrm_mapper u_lcrm_mapper (.i_clk(i_clk), .i_srst(i_srst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .i_mclk_present(i_mclk_present), .i_out_enable_source_sel(i_out_enable_source_sel),
        .i_target_table_select(i_target_table_select), .o_power(o_power), .o_format(o_format),
        .o_native(o_native), .o_level(o_level));
    // Clock of 10 ns period
    always #5 i_clk = ~i_clk;
    // Compare and count
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe, entered at a falling edge
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        i_wr_en = 1'b1;
        i_addr  = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr_en = 1'b0;
    endtask
    // One-cycle read strobe, answer checked in the following cycle
    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        i_rd_en = 1'b1;
        i_addr  = a;
        @(negedge i_clk);
        i_rd_en = 1'b0;
        chk({8'h00, o_rd_valid}, 9'h001);
        chk(o_rdata, exp);
    endtask
    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        repeat (1000) @(posedge i_clk);
        errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (20) @(negedge i_clk);
        i_srst = 1'b0;
        for (int a = 6; a < 13; a++) begin
            rd(7'(a), 9'h000);
            @(negedge i_clk);
        end
        foreach (ROWS[i]) begin
            i_mclk_present = ROWS[i].mclk;
            wr(ROWS[i].wa, ROWS[i].wd);
            rd(ROWS[i].ra, ROWS[i].exp);
            if (ROWS[i].wa == lcrm_pkg::ADDR_RATE) begin
                @(negedge i_clk);
                rd(lcrm_pkg::ADDR_NAT_SRT, {5'h00, ROWS[i].exp[7:5], 1'h0});
                chk({4'h0, o_native.main_div_x2}, (ROWS[i].exp[5] ? 9'h003 : 9'h002) << ROWS[i].exp[7:6]);
            end
        end
        chk({o_level.gate_enable, o_level.gate_threshold_db}, 9'h1E2);
        chk({1'h0, o_level.floor_gain_db}, 9'h01E);
        chk(o_level.ceiling_gain_qdb, 9'h08D);
        chk({o_level.level_ctrl_channel_enable, o_level.target_hdb}, 9'h1F4);
        wr(lcrm_pkg::ADDR_FORMAT, 9'h0D3);
        rd(lcrm_pkg::ADDR_FORMAT, 9'h0D3);
        chk({o_format.dsp_variant_b, o_format.frame_sync_invert, o_format.sample_out_enable,
            o_format.word_bits}, 9'h110);
        chk({o_native.bias_block_enable, o_format.port_role_select, o_format.main_clock_halve,
            4'h0, o_format.frame_format}, 9'h0C3);
        i_out_enable_source_sel = 1'b1;
        i_target_table_select = 1'b1;
        repeat (2) @(negedge i_clk);
        chk({8'h00, o_format.sample_out_enable}, 9'h001);
        chk({2'h0, o_level.target_hdb}, 9'h07D);
        i_srst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_srst = 1'b0;
        rd(lcrm_pkg::ADDR_POWER, 9'h000);
        chk({8'h00, o_power.ref_buffer_on}, 9'h001);
        end_sim();
    end
endmodule
